// [common/ivm_pkg.sv]
// constants for the interrupt vector table map
package ivm_pkg;
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned NUM_TRAP     = 8;
  localparam int unsigned NUM_IRQ      = 118;
  localparam int unsigned VEC_W        = 7;
  localparam int unsigned PRIO_W       = 3;
  localparam logic [23:0] RESET_JUMP   = 24'h000000;
  localparam logic [23:0] RESET_TARGET = 24'h000002;
  localparam logic [23:0] TRAP_BASE    = 24'h000004;
  localparam logic [23:0] IRQ_BASE     = 24'h000014;
  localparam logic [23:0] ALT_OFFSET   = 24'h000100;
  localparam logic [6:0]  IRQ_VEC_OFS  = 7'h08;
  localparam logic [6:0]  MAX_VECTOR   = 7'h7D;
  // request numbers
  localparam int unsigned IRQ_EXT_ZERO   = 0;
  localparam int unsigned IRQ_CAP_ONE    = 1;
  localparam int unsigned IRQ_CMP_ONE    = 2;
  localparam int unsigned IRQ_TMR_ONE    = 3;
  localparam int unsigned IRQ_CAP_TWO    = 5;
  localparam int unsigned IRQ_CMP_TWO    = 6;
  localparam int unsigned IRQ_TMR_TWO    = 7;
  localparam int unsigned IRQ_TMR_THREE  = 8;
  localparam int unsigned IRQ_SER_ERR    = 9;
  localparam int unsigned IRQ_SER_DONE   = 10;
  localparam int unsigned IRQ_UART_RX    = 11;
  localparam int unsigned IRQ_UART_TX    = 12;
  localparam int unsigned IRQ_CONV_DONE  = 13;
  localparam int unsigned IRQ_I2C_TGT    = 16;
  localparam int unsigned IRQ_I2C_CTL    = 17;
  localparam int unsigned IRQ_PIN_CHANGE = 19;
  localparam int unsigned IRQ_EXT_ONE    = 20;
  localparam int unsigned IRQ_CAP_SEVEN  = 22;
  localparam int unsigned IRQ_CAP_EIGHT  = 23;
  localparam int unsigned IRQ_EXT_TWO    = 29;
  localparam int unsigned IRQ_UART_ERR   = 65;
  // trap numbers
  localparam int unsigned TRAP_OSC_FAIL  = 1;
  localparam int unsigned TRAP_ADDR_ERR  = 2;
  localparam int unsigned TRAP_STACK_ERR = 3;
  localparam int unsigned TRAP_MATH_ERR  = 4;
  typedef enum logic [1:0] {
    IVM_RESET_JUMP,
    IVM_RESET_TARGET,
    IVM_RUN
  } ivm_state_e;
endpackage

// [src/ivm_vector_map.sv]
// vector table mapping with traps first and assigned-priority arbitration of requests
`timescale 1ns/1ps
module ivm_vector_map (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // table select
  input  wire logic                 alt_table_sel,
  // trap sources
  input  wire logic                 osc_fail_trap,
  input  wire logic                 addr_error_trap,
  input  wire logic                 stack_error_trap,
  input  wire logic                 math_error_trap,
  // peripheral sources, each with an assigned priority
  input  wire logic                 ext_pin_irq_zero,
  input  wire logic                 capture_unit_one,
  input  wire logic                 compare_unit_one,
  input  wire logic                 timer_one_event,
  input  wire logic                 capture_unit_two,
  input  wire logic                 compare_unit_two,
  input  wire logic                 timer_two_event,
  input  wire logic                 timer_three_event,
  input  wire logic                 serial_periph_error_event,
  input  wire logic                 serial_periph_done_event,
  input  wire logic                 uart_receive_event,
  input  wire logic                 uart_transmit_event,
  input  wire logic                 converter_done_event,
  input  wire logic                 i2c_target_event,
  input  wire logic                 i2c_controller_event,
  input  wire logic                 pin_change_event,
  input  wire logic                 ext_pin_irq_one,
  input  wire logic                 capture_unit_seven,
  input  wire logic                 capture_unit_eight,
  input  wire logic                 ext_pin_irq_two,
  input  wire logic                 uart_error_event,
  input  wire logic [118*3-1:0]     irq_priority,
  // core handshake
  input  wire logic                 core_accept,
  output logic                      fetch_valid,
  output logic [23:0]               fetch_addr,
  output logic [6:0]                fetch_vector,
  output logic                      fetch_is_reset,
  output logic                      req_pending,
  output logic [6:0]                pending_vector
);
  localparam int unsigned NI = ivm_pkg::NUM_IRQ;
  localparam int unsigned NT = ivm_pkg::NUM_TRAP;

  // slot address for a vector in the chosen table
  // traps start at vector 0, so one base serves traps and requests
  function automatic logic [23:0] slot_addr(input logic [6:0] vec,
                                            input logic       alt);
    logic [23:0] a;
    a = ivm_pkg::TRAP_BASE + {16'h0000, vec, 1'b0};
    if (alt) begin
      a = a + ivm_pkg::ALT_OFFSET;
    end
    return a;
  endfunction

  // priority field of one request; a zero field keeps it out
  function automatic logic [ivm_pkg::PRIO_W-1:0] prio_of(
    input logic [ivm_pkg::NUM_IRQ*ivm_pkg::PRIO_W-1:0] all,
    input int                                          n);
    return all[n*ivm_pkg::PRIO_W +: ivm_pkg::PRIO_W];
  endfunction

  // only named requests reach the arbiter; the rest stay tied low
  logic [NI-1:0] irq_raw;
  always_comb begin
    irq_raw = '0;
    irq_raw[ivm_pkg::IRQ_EXT_ZERO]   = ext_pin_irq_zero;
    irq_raw[ivm_pkg::IRQ_CAP_ONE]    = capture_unit_one;
    irq_raw[ivm_pkg::IRQ_CMP_ONE]    = compare_unit_one;
    irq_raw[ivm_pkg::IRQ_TMR_ONE]    = timer_one_event;
    irq_raw[ivm_pkg::IRQ_CAP_TWO]    = capture_unit_two;
    irq_raw[ivm_pkg::IRQ_CMP_TWO]    = compare_unit_two;
    irq_raw[ivm_pkg::IRQ_TMR_TWO]    = timer_two_event;
    irq_raw[ivm_pkg::IRQ_TMR_THREE]  = timer_three_event;
    irq_raw[ivm_pkg::IRQ_SER_ERR]    = serial_periph_error_event;
    irq_raw[ivm_pkg::IRQ_SER_DONE]   = serial_periph_done_event;
    irq_raw[ivm_pkg::IRQ_UART_RX]    = uart_receive_event;
    irq_raw[ivm_pkg::IRQ_UART_TX]    = uart_transmit_event;
    irq_raw[ivm_pkg::IRQ_CONV_DONE]  = converter_done_event;
    irq_raw[ivm_pkg::IRQ_I2C_TGT]    = i2c_target_event;
    irq_raw[ivm_pkg::IRQ_I2C_CTL]    = i2c_controller_event;
    irq_raw[ivm_pkg::IRQ_PIN_CHANGE] = pin_change_event;
    irq_raw[ivm_pkg::IRQ_EXT_ONE]    = ext_pin_irq_one;
    irq_raw[ivm_pkg::IRQ_CAP_SEVEN]  = capture_unit_seven;
    irq_raw[ivm_pkg::IRQ_CAP_EIGHT]  = capture_unit_eight;
    irq_raw[ivm_pkg::IRQ_EXT_TWO]    = ext_pin_irq_two;
    irq_raw[ivm_pkg::IRQ_UART_ERR]   = uart_error_event;
  end

  // trap 0 and traps 5 to 7 are reserved and stay tied low
  logic [NT-1:0] trap_raw;
  always_comb begin
    trap_raw = '0;
    trap_raw[ivm_pkg::TRAP_OSC_FAIL]  = osc_fail_trap;
    trap_raw[ivm_pkg::TRAP_ADDR_ERR]  = addr_error_trap;
    trap_raw[ivm_pkg::TRAP_STACK_ERR] = stack_error_trap;
    trap_raw[ivm_pkg::TRAP_MATH_ERR]  = math_error_trap;
  end

  // traps come first; the lowest set trap number wins
  logic       trap_any;
  logic [6:0] trap_vec;
  always_comb begin
    trap_any = 1'b0;
    trap_vec = '0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (trap_raw[i]) begin
        trap_any = 1'b1;
        trap_vec = 7'(i);
      end
    end
  end

  // requests: highest assigned priority wins; a strict greater-than
  // keeps the lower number on a tie, and a zero field never wins
  logic                       irq_any;
  logic [6:0]                 irq_vec;
  logic [ivm_pkg::PRIO_W-1:0] irq_prio;
  always_comb begin
    irq_any  = 1'b0;
    irq_vec  = '0;
    irq_prio = '0;
    for (int n = 0; n < NI; n++) begin
      if (irq_raw[n] && prio_of(irq_priority, n) != '0 &&
          (!irq_any || prio_of(irq_priority, n) > irq_prio)) begin
        irq_any  = 1'b1;
        irq_prio = prio_of(irq_priority, n);
        irq_vec  = 7'(n) + ivm_pkg::IRQ_VEC_OFS;
      end
    end
  end

  // last pick; nothing past the final table slot is ever offered
  logic       win_any;
  logic [6:0] win_vec;
  always_comb begin
    win_any = trap_any || irq_any;
    win_vec = trap_any ? trap_vec : irq_vec;
    if (win_vec > ivm_pkg::MAX_VECTOR) begin
      win_any = 1'b0;
    end
  end

  assign req_pending    = win_any;
  assign pending_vector = win_vec;

  // boot sequence then one fetch per accepted request
  // a core that never accepts leaves the offer up while a source stays high; nothing times it out
  // the offer is made again a cycle after a take if the source stays high
  ivm_pkg::ivm_state_e state_q, state_d;
  logic        valid_q, valid_d;
  logic [23:0] addr_q, addr_d;
  logic [6:0]  vec_q, vec_d;
  logic        rst_q, rst_d;

  always_comb begin
    state_d = state_q;
    valid_d = valid_q;
    addr_d  = addr_q;
    vec_d   = vec_q;
    rst_d   = rst_q;
    unique case (state_q)
      ivm_pkg::IVM_RESET_JUMP: begin
        // the jump word stands until the core takes it
        valid_d = 1'b1;
        rst_d   = 1'b1;
        addr_d  = ivm_pkg::RESET_JUMP;
        if (valid_q && core_accept) begin
          addr_d  = ivm_pkg::RESET_TARGET;
          state_d = ivm_pkg::IVM_RESET_TARGET;
        end
      end
      ivm_pkg::IVM_RESET_TARGET: begin
        if (core_accept) begin
          valid_d = 1'b0;
          rst_d   = 1'b0;
          state_d = ivm_pkg::IVM_RUN;
        end
      end
      ivm_pkg::IVM_RUN: begin
        // offered address follows the live winner until taken
        valid_d = win_any;
        vec_d   = win_vec;
        addr_d  = slot_addr(win_vec, alt_table_sel);
        if (valid_q && core_accept) begin
          valid_d = 1'b0;
        end
      end
      default: begin
        // unused state code: start the boot fetches again
        state_d = ivm_pkg::IVM_RESET_JUMP;
        valid_d = 1'b0;
        rst_d   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ivm_pkg::IVM_RESET_JUMP;
      valid_q <= 1'b0;
      addr_q  <= '0;
      vec_q   <= '0;
      rst_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      valid_q <= valid_d;
      addr_q  <= addr_d;
      vec_q   <= vec_d;
      rst_q   <= rst_d;
    end
  end

  assign fetch_valid    = valid_q;
  assign fetch_addr     = addr_q;
  assign fetch_vector   = vec_q;
  assign fetch_is_reset = rst_q;
endmodule

// [tb/ivm_core_model.sv]
// core model that takes offered handler fetches
`timescale 1ns/1ps
module ivm_core_model (
  // clock, reset and pace
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  // fetch handshake and record of what was taken
  input  wire logic        fetch_valid,
  input  wire logic [23:0] fetch_addr,
  input  wire logic [6:0]  fetch_vector,
  output logic             core_accept,
  output logic [23:0]      taken_addr,
  output logic [6:0]       taken_vec,
  output int               taken_cnt
);
  logic seen;
  // a slow core lets each offer that follows a low fetch_valid stand one extra cycle before taking it
  always @(negedge clk or posedge reset) begin
    if (reset) begin
      seen <= 1'h0;
      core_accept <= 1'h0;
    end else begin
      seen <= fetch_valid;
      core_accept <= fetch_valid && (!slow || seen);
    end
  end
  always @(posedge clk or posedge reset) begin
    if (reset) taken_cnt <= 0;
    else if (fetch_valid && core_accept) begin
      taken_addr <= fetch_addr;
      taken_vec <= fetch_vector;
      taken_cnt <= taken_cnt + 1;
    end
  end
endmodule

// [tb/ivm_vector_map_properties.sv]
// port checks for the vector map
`timescale 1ns/1ps
module ivm_map_checker (
  // watched ports
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        alt_table_sel,
  input wire logic        osc_fail_trap,
  input wire logic        core_accept,
  input wire logic        fetch_valid,
  input wire logic [23:0] fetch_addr,
  input wire logic [6:0]  fetch_vector,
  input wire logic        fetch_is_reset,
  input wire logic        req_pending,
  input wire logic [6:0]  pending_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic run;
  assign run = fetch_valid && !fetch_is_reset;
  a_boot_start: assert property ($fell(reset) |=>
    fetch_valid && fetch_is_reset && fetch_addr == 24'h000000)
    else $error("no boot jump");
  a_boot_target: assert property (fetch_is_reset && fetch_valid &&
    core_accept && fetch_addr == 24'h000000 |=> fetch_addr == 24'h000002)
    else $error("no boot target");
  a_slot_addr: assert property (run |->
    fetch_addr[23:9] == 15'h0000 &&
    fetch_addr[7:0] == 8'h04 + {fetch_vector, 1'h0}) else $error("bad slot");
  a_slot_table: assert property (run && $stable(alt_table_sel) |->
    fetch_addr[8] == alt_table_sel) else $error("wrong table");
  a_offer_gap: assert property (run && core_accept |=>
    !fetch_valid) else $error("offer not withdrawn");
  a_vec_winner: assert property (run |->
    fetch_vector == $past(pending_vector)) else $error("not the winner");
  a_legal_vec: assert property (req_pending |->
    pending_vector inside {[7'h01:7'h04], [7'h08:7'h0B], [7'h0D:7'h15],
    7'h18, 7'h19, 7'h1B, 7'h1C, 7'h1E, 7'h1F, 7'h25, 7'h49})
    else $error("reserved vector");
  a_trap_first: assert property (osc_fail_trap && !fetch_is_reset |->
    req_pending && pending_vector == 7'h01) else $error("trap not first");
  c_alt_take: cover property (run && core_accept && alt_table_sel);
  c_trap_take: cover property (run && core_accept && fetch_vector == 7'h04);
  c_boot_done: cover property (fetch_is_reset ##1 !fetch_is_reset);
endmodule
bind ivm_vector_map ivm_map_checker u_chk (.*);

// [tb/tb_interrupt_vector_table_map.sv]
// self-checking bench for the vector table map
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  bad_count++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end end
module tb_interrupt_vector_table_map;
  logic         clk, reset, alt_table_sel, slow, core_accept, fetch_valid;
  logic         fetch_is_reset, req_pending;
  logic [20:0]  src;
  logic [3:0]   trap;
  logic [353:0] prio;
  logic [23:0]  fetch_addr, taken_addr;
  logic [6:0]   fetch_vector, pending_vector, taken_vec;
  int           taken_cnt, bad_count, check_count;
  int           nums[21] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16,
                             17, 19, 20, 22, 23, 29, 65};
  always #5 clk = ~clk;
  ivm_core_model u_core (.*);
  ivm_vector_map u_dut (.osc_fail_trap(trap[0]), .addr_error_trap(trap[1]),
    .stack_error_trap(trap[2]), .math_error_trap(trap[3]),
    .ext_pin_irq_zero(src[0]), .capture_unit_one(src[1]),
    .compare_unit_one(src[2]), .timer_one_event(src[3]),
    .capture_unit_two(src[4]), .compare_unit_two(src[5]),
    .timer_two_event(src[6]), .timer_three_event(src[7]),
    .serial_periph_error_event(src[8]), .serial_periph_done_event(src[9]),
    .uart_receive_event(src[10]), .uart_transmit_event(src[11]),
    .converter_done_event(src[12]), .i2c_target_event(src[13]),
    .i2c_controller_event(src[14]), .pin_change_event(src[15]),
    .ext_pin_irq_one(src[16]), .capture_unit_seven(src[17]),
    .capture_unit_eight(src[18]), .ext_pin_irq_two(src[19]),
    .uart_error_event(src[20]), .irq_priority(prio), .*);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait for the core to take fetch number n
  task automatic take(input int n);
    for (int i = 0; i < 40 && taken_cnt < n; i++) @(negedge clk);
    if (taken_cnt < n) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic boot_words();
    take(1);
    `CHK("boot jump", 24'h000000, taken_addr)
    `CHK("boot flag", 1'h1, fetch_is_reset)
    take(2);
    `CHK("boot target", 24'h000002, taken_addr)
    `CHK("boot flag clear", 1'h0, fetch_is_reset)
  endtask
  // one source at a time, dropped at once so it is never offered twice
  task automatic sweep(input logic a, input logic s);
    int          v;
    logic [23:0] exp_addr;
    alt_table_sel = a;
    slow = s;
    for (int k = 1; k < 26; k++) begin
      @(negedge clk);
      if (k < 5) trap[k-1] = 1'h1;
      else src[k-5] = 1'h1;
      take(taken_cnt + 1);
      trap = '0;
      src = '0;
      v = (k < 5) ? k : nums[k-5] + 8;
      exp_addr = (a ? 24'h000104 : 24'h000004) + 24'(2 * v);
      `CHK("slot", exp_addr, taken_addr)
      `CHK("vector", 7'(v), taken_vec)
    end
  endtask
  // trap beats requests, then the lower number wins at equal priority
  task automatic order_check();
    @(negedge clk);
    trap[3] = 1'h1;
    src = 21'h000408;
    take(taken_cnt + 1);
    trap = '0;
    `CHK("trap first", 7'h04, taken_vec)
    take(taken_cnt + 1);
    src = 21'h000400;
    `CHK("low number", 7'h0B, taken_vec)
    take(taken_cnt + 1);
    src = '0;
    `CHK("last request", 7'h13, taken_vec)
  endtask
  // a higher assigned priority beats natural order; zero never wins
  task automatic prio_check();
    @(negedge clk);
    prio[11*3 +: 3] = 3'h6;
    prio[0 +: 3] = 3'h0;
    src = 21'h000409;
    take(taken_cnt + 1);
    src = 21'h000009;
    `CHK("higher priority", 7'h13, taken_vec)
    take(taken_cnt + 1);
    src = '0;
    prio = {118{3'h4}};
    `CHK("zero priority skipped", 7'h0B, taken_vec)
  endtask
  initial begin
    clk = 1'h0;
    reset = 1'h1;
    alt_table_sel = 1'h0;
    slow = 1'h0;
    src = '0;
    trap = '0;
    prio = {118{3'h4}};
    repeat (16) @(negedge clk);
    reset = 1'h0;
    boot_words();
    sweep(1'h0, 1'h0);
    sweep(1'h1, 1'h1);
    order_check();
    prio_check();
    reset = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    boot_words();
    print_verdict();
  end
endmodule
